// file: src/aip_map.vh
// Register offsets, field positions and reset values of the input image packer
`ifndef AIP_MAP_VH
`define AIP_MAP_VH
`define AIP_OFS_CH0        12'h000
`define AIP_OFS_CH1        12'h004
`define AIP_OFS_CH2        12'h008
`define AIP_OFS_CH3        12'h00C
`define AIP_OFS_STATUS     12'h010
`define AIP_OFS_DIN_LO     12'h014
`define AIP_OFS_DIN_HI     12'h018
`define AIP_OFS_FAULT_CFG  12'h01C
`define AIP_OFS_IRQ_STAT   12'h020
`define AIP_OFS_IRQ_EN     12'h024
`define AIP_OFS_IRQ_CLR    12'h028
`define AIP_CONV_W         12
`define AIP_DIN_HI_W       8
`define AIP_NCH            4
`define AIP_EV_W           3
`define AIP_EV_STATUS      0
`define AIP_EV_DIN         1
`define AIP_EV_FAULT       2
`define AIP_RST_WORD       32'h00000000
`define AIP_RST_CONV       12'h000
`define AIP_RST_PINS       40'h000000F000
`define AIP_RST_FMAP       4'hF
`endif

// file: src/aip_image_packer.v
// Input data image packer: four analog channels, status word, 24 discrete bits, AHB-Lite slave
// Behaviour
// - Words 0..3 carry channel conversion in bits 0..11; bits 12..31 read zero.
// - Word 4 holds one status bit per channel in bits 0..3; rest zero.
// - Status set on missing field power, or open wire/under range in 4-20 mA.
// - A module fault sets the status bit of every channel it affects.
// - Word 5 presents discrete inputs 0..15 in bits 0..15.
// - Word 6 presents discrete inputs 16..23 in bits 0..7.
`timescale 1ns/1ps
`include "aip_map.vh"
module aip_image_packer #(
    parameter CONV_W = 12,
    parameter NCH    = 4
) (
    // AHB-Lite slave
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Clock enable
    input  wire        clk_en,
    // Conversion results, same clock domain
    input  wire [47:0] conv_data,
    input  wire [3:0]  conv_valid,
    // Channel condition pins
    input  wire [3:0]  field_power_ok,
    input  wire [3:0]  open_wire,
    input  wire [3:0]  under_range,
    input  wire [3:0]  range_4_20,
    input  wire        fault_recov,
    input  wire        fault_unrecov,
    // Discrete expansion pins
    input  wire [23:0] discrete_in,
    // Interrupt
    output reg         irq
);
    // Pin bundle: discrete inputs, then power, open wire, under range, range select
    localparam PIN_W = 40;
    localparam DIN_W = 24;
    localparam EV_W  = `AIP_EV_W;

    // Condition and discrete pins, three-stage synchronisers
    reg  [PIN_W-1:0] sync1_reg;
    reg  [PIN_W-1:0] sync2_reg;
    reg  [PIN_W-1:0] sync3_reg;
    reg  [PIN_W-1:0] clean_reg;
    wire [PIN_W-1:0] raw_pins;
    wire [PIN_W-1:0] pin_agree;
    wire [PIN_W-1:0] clean_next;

    assign raw_pins   = {discrete_in, field_power_ok, open_wire, under_range, range_4_20};
    // A change counts only once stages two and three agree
    assign pin_agree  = ~(sync2_reg ^ sync3_reg);
    assign clean_next = (pin_agree & sync3_reg) | (~pin_agree & clean_reg);

    // Power resets to present, so no false status shows right after reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= `AIP_RST_PINS;
            sync2_reg <= `AIP_RST_PINS;
            sync3_reg <= `AIP_RST_PINS;
            clean_reg <= `AIP_RST_PINS;
        end else if (clk_en) begin
            sync1_reg <= raw_pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            clean_reg <= clean_next;
        end
    end

    wire [DIN_W-1:0] din_s;
    wire [3:0]       pwr_s;
    wire [3:0]       open_s;
    wire [3:0]       undr_s;
    wire [3:0]       rng_s;

    assign din_s  = clean_reg[39:16];
    assign pwr_s  = clean_reg[15:12];
    assign open_s = clean_reg[11:8];
    assign undr_s = clean_reg[7:4];
    assign rng_s  = clean_reg[3:0];

    // Fault pins synchronised the same way
    reg  [1:0]       fs1_reg;
    reg  [1:0]       fs2_reg;
    reg  [1:0]       fs3_reg;
    reg  [1:0]       fclean_reg;
    wire [1:0]       fault_agree;
    wire [1:0]       fclean_next;

    assign fault_agree = ~(fs2_reg ^ fs3_reg);
    assign fclean_next = (fault_agree & fs3_reg) | (~fault_agree & fclean_reg);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fs1_reg    <= 2'h0;
            fs2_reg    <= 2'h0;
            fs3_reg    <= 2'h0;
            fclean_reg <= 2'h0;
        end else if (clk_en) begin
            fs1_reg    <= {fault_unrecov, fault_recov};
            fs2_reg    <= fs1_reg;
            fs3_reg    <= fs2_reg;
            fclean_reg <= fclean_next;
        end
    end

    // Bus address phase decode
    reg              ph_act_reg;
    reg              ph_wr_reg;
    reg  [11:0]      ph_addr_reg;
    wire             take;
    wire             wr_phase;
    wire             wr_fault_map;
    wire             wr_irq_en;
    wire             wr_irq_clr;

    assign take         = hsel & hready & htrans[1];
    // Writes land at the end of the data phase, while hwdata stands
    assign wr_phase     = ph_act_reg & ph_wr_reg;
    assign wr_fault_map = wr_phase & (ph_addr_reg == `AIP_OFS_FAULT_CFG);
    assign wr_irq_en    = wr_phase & (ph_addr_reg == `AIP_OFS_IRQ_EN);
    assign wr_irq_clr   = wr_phase & (ph_addr_reg == `AIP_OFS_IRQ_CLR);
    // Limitation: hsize is not checked; only whole-word transfers are expected

    // Software registers and image state
    reg  [3:0]       fault_map_reg;
    reg  [EV_W-1:0]  irq_stat_reg;
    reg  [EV_W-1:0]  irq_en_reg;
    reg  [47:0]      conv_reg;
    reg  [3:0]       status_reg;
    reg  [DIN_W-1:0] din_reg;

    // Fault reaches every channel selected in the fault map
    wire             any_fault;
    wire [3:0]       fault_ch;
    wire [3:0]       status_next;

    assign any_fault = fclean_reg[0] | fclean_reg[1];
    assign fault_ch  = any_fault ? fault_map_reg : 4'h0;

    // Per-channel status condition
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chan
            wire no_power;
            wire loop_fail;
            assign no_power  = ~pwr_s[g];
            // Open wire and under range count only in the 4-20 mA range
            assign loop_fail = rng_s[g] & (open_s[g] | undr_s[g]);
            // Clear whenever no condition is present
            assign status_next[g] = no_power | loop_fail | fault_ch[g];
        end
    endgenerate

    // Conversion capture per channel; results share the clock, so no synchroniser
    integer i;
    reg [47:0] conv_next;
    always @* begin
        conv_next = conv_reg;
        for (i = 0; i < NCH; i = i + 1) begin
            if (conv_valid[i]) begin
                conv_next[i*CONV_W +: CONV_W] = conv_data[i*CONV_W +: CONV_W];
            end
        end
    end

    // Events that latch into the interrupt status
    wire [EV_W-1:0]  ev_now;
    wire [EV_W-1:0]  clr_mask;
    wire [EV_W-1:0]  irq_stat_next;

    assign ev_now[`AIP_EV_STATUS] = status_next != status_reg;
    assign ev_now[`AIP_EV_DIN]    = din_s != din_reg;
    assign ev_now[`AIP_EV_FAULT]  = any_fault & (status_next != status_reg);
    assign clr_mask      = wr_irq_clr ? hwdata[EV_W-1:0] : {EV_W{1'b0}};
    // A new event wins over a clear in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~clr_mask) | ev_now;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_reg   <= 48'h000000000000;
            status_reg <= 4'h0;
            din_reg    <= 24'h000000;
        end else if (clk_en) begin
            conv_reg   <= conv_next;
            status_reg <= status_next;
            din_reg    <= din_s;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_map_reg <= `AIP_RST_FMAP;
        end else if (clk_en & wr_fault_map) begin
            fault_map_reg <= hwdata[3:0];
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_reg <= {EV_W{1'b0}};
        end else if (clk_en & wr_irq_en) begin
            irq_en_reg <= hwdata[EV_W-1:0];
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= {EV_W{1'b0}};
        end else if (clk_en) begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Level interrupt, one edge behind the status bits
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Image words, unused upper bits tied to zero
    wire [31:0]      word_ch0;
    wire [31:0]      word_ch1;
    wire [31:0]      word_ch2;
    wire [31:0]      word_ch3;
    wire [31:0]      word_status;
    wire [31:0]      word_din_lo;
    wire [31:0]      word_din_hi;

    assign word_ch0    = {20'h00000, conv_reg[11:0]};
    assign word_ch1    = {20'h00000, conv_reg[23:12]};
    assign word_ch2    = {20'h00000, conv_reg[35:24]};
    assign word_ch3    = {20'h00000, conv_reg[47:36]};
    assign word_status = {28'h0000000, status_reg};
    assign word_din_lo = {16'h0000, din_reg[15:0]};
    assign word_din_hi = {24'h000000, din_reg[23:16]};

    // Read mux
    reg [31:0] rd_next;
    always @* begin
        rd_next = `AIP_RST_WORD;
        case (haddr)
            `AIP_OFS_CH0:       rd_next = word_ch0;
            `AIP_OFS_CH1:       rd_next = word_ch1;
            `AIP_OFS_CH2:       rd_next = word_ch2;
            `AIP_OFS_CH3:       rd_next = word_ch3;
            `AIP_OFS_STATUS:    rd_next = word_status;
            `AIP_OFS_DIN_LO:    rd_next = word_din_lo;
            `AIP_OFS_DIN_HI:    rd_next = word_din_hi;
            `AIP_OFS_FAULT_CFG: rd_next = {28'h0000000, fault_map_reg};
            `AIP_OFS_IRQ_STAT:  rd_next = {29'h00000000, irq_stat_reg};
            `AIP_OFS_IRQ_EN:    rd_next = {29'h00000000, irq_en_reg};
            default:            rd_next = `AIP_RST_WORD;
        endcase
    end

    // Zero-wait slave; address phase captured for the write at the data phase end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_act_reg  <= 1'b0;
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= 12'h000;
        end else if (clk_en) begin
            ph_act_reg  <= take;
            ph_wr_reg   <= hwrite;
            ph_addr_reg <= haddr;
        end
    end

    // Read data registered at the address phase edge, held until the next read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `AIP_RST_WORD;
        end else if (clk_en & take & ~hwrite) begin
            hrdata <= rd_next;
        end
    end

    // Never a wait state and never an error
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule // aip_image_packer

// file: verification/aip_checker_assertions.sv
// Concurrent checks on the image packer's bus answers
`timescale 1ns/1ps
module aip_checker (
    input wire        hclk, hresetn, hsel, hwrite, hready, clk_en, hreadyout, hresp, fault_recov,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire [31:0] hrdata,
    input wire [3:0]  field_power_ok
);
    wire rd = hsel && hready && htrans[1] && !hwrite && clk_en;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ch_hi; rd && haddr < 12'h010 |=> hrdata[31:12] == 20'h0; endproperty
    a_ch_hi: assert property (p_ch_hi) else $error("channel word upper bits set");
    property p_st_hi; rd && haddr == 12'h010 |=> hrdata[31:4] == 28'h0; endproperty
    a_st_hi: assert property (p_st_hi) else $error("status upper bits set");
    property p_dh_hi; rd && haddr == 12'h018 |=> hrdata[31:8] == 24'h0; endproperty
    a_dh_hi: assert property (p_dh_hi) else $error("discrete high upper bits set");
    property p_pwr; rd && haddr == 12'h010 && field_power_ok == 4'h0 && $past(field_power_ok, 8) == 4'h0
        |=> hrdata[3:0] == 4'hF; endproperty
    a_pwr: assert property (p_pwr) else $error("missing power not flagged");
    property p_flt; rd && haddr == 12'h010 && fault_recov && $past(fault_recov, 8) |=> hrdata[3:0] == 4'hF;
    endproperty
    a_flt: assert property (p_flt) else $error("fault not flagged on all channels");
    property p_unm; rd && haddr == 12'h02C |=> hrdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_hold; !rd |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_ok; hreadyout && !hresp; endproperty
    a_ok: assert property (p_ok) else $error("wait state or error response");
endmodule // aip_checker
bind aip_image_packer aip_checker chk (.*);

// file: verification/aip_adapter.sv
// Network adapter model: polls the image as an AHB-Lite master
`timescale 1ns/1ps
module aip_adapter (
    input  wire        hclk,
    input  wire        hready,
    input  wire [31:0] hrdata,
    output logic       hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic       hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    logic tmo;
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, tmo} = '0;
    end
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        do begin @(posedge hclk); n++; end while (!hready && n < 20);
        tmo = !hready;
        htrans <= 2'h0; hwdata <= w ? wd : ~hwdata;
        do begin @(posedge hclk); n++; end while (!hready && n < 40);
        d = hrdata;
        tmo = tmo | !hready;
    endtask
endmodule // aip_adapter

// file: verification/tb.sv
// Self-checking bench for the input image packer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
module tb;
    logic hclk = 0, hresetn = 0, irq, hready, hresp;
    logic hsel, hwrite; logic [11:0] haddr; logic [1:0] htrans; logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d;
    logic [47:0] conv = 48'h5A5FFF123ABC;
    logic [3:0] pwr = 4'hF, ow = 0, ur = 0, rng = 0, cv = 4'hF;
    logic f_r = 0, f_u = 0;
    logic [23:0] din = 24'hC3A55A;
    logic [23:0] tbl [6] = '{24'h0E0001, 24'h0F2022, 24'h0F0400, 24'h0F0888, 24'h1F000F, 24'h00000F};
    int err_total = 0, compares = 0;
    always #12.5 hclk = ~hclk;
    aip_adapter m (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    aip_image_packer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .clk_en(1'b1), .conv_data(conv), .conv_valid(cv),
        .field_power_ok(pwr), .open_wire(ow), .under_range(ur), .range_4_20(rng),
        .fault_recov(f_r), .fault_unrecov(f_u), .discrete_in(din), .irq(irq));
    task end_of_test;
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task xf(input logic [11:0] a, input logic w, input logic [31:0] wd);
        m.xfer(a, w, wd, d);
        if (m.tmo) begin err_total++; end_of_test; end
    endtask
    task wirq(input logic v);
        int n;
        for (n = 0; n < 30 && irq !== v; n++) @(posedge hclk);
        `CHK(irq, v)
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            xf(12'h000 + 4 * i, 0, 0); `CHK(d, {20'h0, conv[12 * i +: 12]})
        end
        xf(12'h000, 1, 32'hFFFFFFFF); xf(12'h000, 0, 0); `CHK(d, 32'h00000ABC)
        xf(12'h014, 0, 0); `CHK(d, 32'h0000A55A)
        xf(12'h018, 0, 0); `CHK(d, 32'h000000C3)
        xf(12'h010, 0, 0); `CHK(d, 32'h0)
        xf(12'h02C, 0, 0); `CHK(d, 32'h0)
        xf(12'h024, 1, 32'h1); xf(12'h028, 1, 32'h7);
        foreach (tbl[k]) begin
            @(posedge hclk);
            {f_u, f_r, pwr, ow, ur, rng} <= tbl[k][21:4];
            repeat (10) @(posedge hclk);
            xf(12'h010, 0, 0); `CHK(d, {28'h0, tbl[k][3:0]})
        end
        wirq(1);
        xf(12'h020, 0, 0); `CHK(d[0], 1'b1)
        xf(12'h024, 1, 32'h0); wirq(0);
        xf(12'h028, 1, 32'h7); xf(12'h024, 1, 32'h1); wirq(0);
        @(posedge hclk);
        {f_u, f_r, pwr, ur} <= 10'h0F0;
        din <= 24'h3C5AA5;
        repeat (10) @(posedge hclk);
        xf(12'h010, 0, 0); `CHK(d, 32'h0)
        xf(12'h018, 0, 0); `CHK(d, 32'h0000003C)
        end_of_test;
    end
endmodule // tb
